// *** hdl/plsgen_chan.v ***
`timescale 1ns/1ns
module plsgen_chan (
  input wire clock,
  input wire rst,
  input wire run,
  input wire tick,
  input wire defer,
  input wire [15:0] hi_rl,
  input wire [15:0] lo_rl,
  output wire level,
  output wire phase_hi,
  output wire [15:0] count,
  output reg end_low,
  output reg end_high
);
  reg running;
  reg phase;
  reg armed;
  reg [15:0] cnt;
  reg [15:0] shadow;

  always @(posedge clock) begin
    if (rst) begin
      running <= 1'b0;
      phase <= 1'b0;
      armed <= 1'b0;
      cnt <= 16'h0000;
      shadow <= 16'h0000;
      end_low <= 1'b0;
      end_high <= 1'b0;
    end else begin
      end_low <= 1'b0;
      end_high <= 1'b0;
      if (!run) begin
        running <= 1'b0;
        phase <= 1'b0;
        armed <= 1'b0;
      end else if (!running) begin
        running <= 1'b1;
        phase <= 1'b0;
        if (defer) begin
          armed <= 1'b1;
        end else begin
          cnt <= lo_rl;
          shadow <= hi_rl;
        end
      end else if (tick) begin
        if (armed) begin
          // output side takes its widths at the first prescaler edge
          armed <= 1'b0;
          cnt <= lo_rl;
          shadow <= hi_rl;
        end else if (cnt == 16'h0000) begin
          if (phase) begin
            phase <= 1'b0;
            cnt <= lo_rl;
            shadow <= hi_rl;
            end_high <= 1'b1;
          end else begin
            phase <= 1'b1;
            cnt <= shadow;
            end_low <= 1'b1;
          end
        end else begin
          cnt <= cnt - 16'h0001;
        end
      end
    end
  end

  assign level = running & phase & ~armed;
  assign phase_hi = phase;
  assign count = cnt;
endmodule // plsgen_chan

// *** hdl/plsgen_div.v ***
`timescale 1ns/1ns
module plsgen_div (
  input wire clock,
  input wire rst,
  input wire [1:0] sel,
  output wire tick
);
`include "plsgen_regs.vh"
  reg [5:0] pre;

  function [5:0] div_mask;
    input [1:0] s;
    begin
      case (s)
        2'h0: div_mask = `PLSGEN_DIV1_MASK;
        2'h1: div_mask = `PLSGEN_DIV4_MASK;
        2'h2: div_mask = `PLSGEN_DIV16_MASK;
        default: div_mask = `PLSGEN_DIV64_MASK;
      endcase
    end
  endfunction

  // free running so ganged channels with equal settings stay aligned
  always @(posedge clock) begin
    if (rst)
      pre <= 6'h00;
    else
      pre <= pre + 6'h01;
  end

  assign tick = ((pre & div_mask(sel)) == div_mask(sel));
endmodule // plsgen_div

// *** hdl/plsgen_regs.vh ***
`ifndef PLSGEN_REGS_VH
`define PLSGEN_REGS_VH
// ==========================================
// register byte offsets
`define PLSGEN_CTRL0_OFS 8'h00
`define PLSGEN_CTRL1_OFS 8'h04
`define PLSGEN_START_OFS 8'h08
`define PLSGEN_HI0_OFS 8'h0c
`define PLSGEN_LO0_OFS 8'h10
`define PLSGEN_HI1_OFS 8'h14
`define PLSGEN_LO1_OFS 8'h18
`define PLSGEN_STAT_OFS 8'h1c
`define PLSGEN_CNT0_OFS 8'h20
`define PLSGEN_CNT1_OFS 8'h24
// ==========================================
// channel control field positions
`define PLSGEN_DIV_LSB 0
`define PLSGEN_DIV_MSB 1
`define PLSGEN_MODE_LSB 2
`define PLSGEN_MODE_MSB 3
`define PLSGEN_FTS_BIT 4
`define PLSGEN_UF_BIT 5
`define PLSGEN_IEN_BIT 6
`define PLSGEN_POL_BIT 7
// ==========================================
// operation modes
`define PLSGEN_MODE_8 2'h0
`define PLSGEN_MODE_8P8 2'h1
`define PLSGEN_MODE_16 2'h2
// ==========================================
// reset values
`define PLSGEN_CTRL_RST 8'h00
`define PLSGEN_RELOAD_RST 8'h00
`define PLSGEN_START_RST 2'h0
// ==========================================
// divider masks: tick when masked prescale count is all ones
`define PLSGEN_DIV1_MASK 6'h00
`define PLSGEN_DIV4_MASK 6'h03
`define PLSGEN_DIV16_MASK 6'h0f
`define PLSGEN_DIV64_MASK 6'h3f
`endif

// *** hdl/plsgen_top.v ***
// Functional notes
// - divide select gives 1, 4, 16, 64
// - output side counts both prescaler edges
// - phase lasts reload plus one periods
// - 16-bit mode concatenates reload pairs
// - reloads writable while running
// - high to low loads low reload
// - low to high loads shadow buffer
// - shadow keeps old pair consistent
// - flag timing select picks phase ends
// - 16-bit mode sets both flags together
// - writing zero clears underflow flag
// - interrupt is flag and enable
// - inversion makes idle level high
// - inversion swaps pin widths
// - inverted select one flags low end
// - inversion also inverts supplied clock
// - start bit starts and stops
// - mode field selects 8, 8+8, 16
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
module plsgen_top (
  input wire clock,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg pulse_out0,
  output reg pulse_out1,
  output reg irq0,
  output reg irq1
);
`include "plsgen_regs.vh"
  // ==========================================
  // register state
  reg [7:0] ctrl0;
  reg [7:0] ctrl1;
  reg [1:0] start;
  reg [7:0] hi0;
  reg [7:0] lo0;
  reg [7:0] hi1;
  reg [7:0] lo1;
  reg pulse_prev1;

  wire acc;
  wire wr;
  wire [1:0] mode;
  wire mode16;
  wire mode8p8;
  wire tick0;
  wire tick1;
  wire div_tick0;
  wire div_tick1;
  wire [15:0] hi_rl0;
  wire [15:0] lo_rl0;
  wire [15:0] hi_rl1;
  wire [15:0] lo_rl1;
  wire level0;
  wire level1;
  wire ph0;
  wire ph1;
  wire [15:0] cnt0;
  wire [15:0] cnt1;
  wire el0;
  wire eh0;
  wire el1;
  wire eh1;
  wire set0;
  wire set1;
  wire [7:0] next_ctrl0;
  wire [7:0] next_ctrl1;
  wire setup;
  wire hit;
  wire wr_ctrl0;
  wire wr_ctrl1;
  wire next_pulse0;
  wire next_pulse1;

  function flag_set;
    input end_low;
    input end_high;
    input fts;
    begin
      // inversion needs no term: raw high end is the pin low end
      flag_set = end_high | (~fts & end_low);
    end
  endfunction

  function [7:0] ctrl_next;
    input [7:0] cur;
    input do_wr;
    input [7:0] wdata;
    input hw_set;
    input keep_mode;
    reg [7:0] v;
    begin
      v = cur;
      if (do_wr) begin
        v = wdata;
        // writing one leaves the flag alone
        v[`PLSGEN_UF_BIT] = cur[`PLSGEN_UF_BIT] & wdata[`PLSGEN_UF_BIT];
        if (keep_mode)
          v[`PLSGEN_MODE_MSB:`PLSGEN_MODE_LSB] = 2'h0;
      end
      // set beats a clear in the same cycle
      if (hw_set)
        v[`PLSGEN_UF_BIT] = 1'b1;
      ctrl_next = v;
    end
  endfunction

  // every register is one aligned word; anything else is refused
  function is_mapped;
    input [7:0] a;
    begin
      case (a)
        `PLSGEN_CTRL0_OFS: is_mapped = 1'b1;
        `PLSGEN_CTRL1_OFS: is_mapped = 1'b1;
        `PLSGEN_START_OFS: is_mapped = 1'b1;
        `PLSGEN_HI0_OFS: is_mapped = 1'b1;
        `PLSGEN_LO0_OFS: is_mapped = 1'b1;
        `PLSGEN_HI1_OFS: is_mapped = 1'b1;
        `PLSGEN_LO1_OFS: is_mapped = 1'b1;
        `PLSGEN_STAT_OFS: is_mapped = 1'b1;
        `PLSGEN_CNT0_OFS: is_mapped = 1'b1;
        `PLSGEN_CNT1_OFS: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction

  // ==========================================
  // apb decode
  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;

  assign setup = psel & ~penable;
  assign hit = is_mapped(paddr);

  assign mode = ctrl0[`PLSGEN_MODE_MSB:`PLSGEN_MODE_LSB];
  assign mode16 = (mode == `PLSGEN_MODE_16);
  assign mode8p8 = (mode == `PLSGEN_MODE_8P8);

  // ==========================================
  // count clocks
  plsgen_div u_div0 (
    .clock(clock),
    .rst(rst),
    .sel(ctrl0[`PLSGEN_DIV_MSB:`PLSGEN_DIV_LSB]),
    .tick(div_tick0)
  );

  plsgen_div u_div1 (
    .clock(clock),
    .rst(rst),
    .sel(ctrl1[`PLSGEN_DIV_MSB:`PLSGEN_DIV_LSB]),
    .tick(div_tick1)
  );

  // prescaler side pin already carries its inversion, so the edges seen
  // here are those of the inverted clock
  assign tick0 = mode8p8 ? (pulse_out1 != pulse_prev1) : div_tick0;
  assign tick1 = div_tick1;

  // ==========================================
  // reload selection
  assign hi_rl0 = mode16 ? {hi1, hi0} : {8'h00, hi0};
  assign lo_rl0 = mode16 ? {lo1, lo0} : {8'h00, lo0};
  assign hi_rl1 = {8'h00, hi1};
  assign lo_rl1 = {8'h00, lo1};

  plsgen_chan u_chan0 (
    .clock(clock),
    .rst(rst),
    .run(start[0]),
    .tick(tick0),
    .defer(mode8p8),
    .hi_rl(hi_rl0),
    .lo_rl(lo_rl0),
    .level(level0),
    .phase_hi(ph0),
    .count(cnt0),
    .end_low(el0),
    .end_high(eh0)
  );

  // in 16-bit mode this core is unused; its pin follows channel 0
  plsgen_chan u_chan1 (
    .clock(clock),
    .rst(rst),
    .run(start[1] & ~mode16),
    .tick(tick1),
    .defer(1'b0),
    .hi_rl(hi_rl1),
    .lo_rl(lo_rl1),
    .level(level1),
    .phase_hi(ph1),
    .count(cnt1),
    .end_low(el1),
    .end_high(eh1)
  );

  // ==========================================
  // underflow flags
  assign set0 = flag_set(el0, eh0, ctrl0[`PLSGEN_FTS_BIT]);
  assign set1 = mode16 ? set0 : flag_set(el1, eh1, ctrl1[`PLSGEN_FTS_BIT]);

  // control words merge the bus write with the hardware flag set
  assign wr_ctrl0 = wr && (paddr == `PLSGEN_CTRL0_OFS);
  assign wr_ctrl1 = wr && (paddr == `PLSGEN_CTRL1_OFS);
  assign next_ctrl0 = ctrl_next(ctrl0, wr_ctrl0, pwdata[7:0], set0, 1'b0);
  assign next_ctrl1 = ctrl_next(ctrl1, wr_ctrl1, pwdata[7:0], set1, 1'b1);

  // ==========================================
  // register writes
  always @(posedge clock) begin
    if (rst) begin
      ctrl0 <= `PLSGEN_CTRL_RST;
      ctrl1 <= `PLSGEN_CTRL_RST;
      start <= `PLSGEN_START_RST;
      hi0 <= `PLSGEN_RELOAD_RST;
      lo0 <= `PLSGEN_RELOAD_RST;
      hi1 <= `PLSGEN_RELOAD_RST;
      lo1 <= `PLSGEN_RELOAD_RST;
    end else begin
      ctrl0 <= next_ctrl0;
      ctrl1 <= next_ctrl1;
      if (wr) begin
        case (paddr)
          // both start bits in one write keeps ganged channels in step
          `PLSGEN_START_OFS: start <= pwdata[1:0];
          // no run check: shadow and load points keep pairs coherent
          `PLSGEN_HI0_OFS: hi0 <= pwdata[7:0];
          `PLSGEN_LO0_OFS: lo0 <= pwdata[7:0];
          `PLSGEN_HI1_OFS: hi1 <= pwdata[7:0];
          `PLSGEN_LO1_OFS: lo1 <= pwdata[7:0];
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================
  // apb answer: one access cycle, data captured in setup
  always @(posedge clock) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      if (setup) begin
        // unmapped words answer with an error and read as zero
        pslverr <= ~hit;
        case (paddr)
          `PLSGEN_CTRL0_OFS: prdata <= {24'h000000, ctrl0};
          `PLSGEN_CTRL1_OFS: prdata <= {24'h000000, ctrl1};
          `PLSGEN_START_OFS: prdata <= {30'h0, start};
          `PLSGEN_HI0_OFS: prdata <= {24'h000000, hi0};
          `PLSGEN_LO0_OFS: prdata <= {24'h000000, lo0};
          `PLSGEN_HI1_OFS: prdata <= {24'h000000, hi1};
          `PLSGEN_LO1_OFS: prdata <= {24'h000000, lo1};
          `PLSGEN_STAT_OFS: prdata <= {28'h0000000, ph1, ph0, pulse_out1, pulse_out0};
          `PLSGEN_CNT0_OFS: prdata <= {16'h0000, cnt0};
          `PLSGEN_CNT1_OFS: prdata <= {16'h0000, cnt1};
          default: begin
            prdata <= 32'h00000000;
          end
        endcase
      end else begin
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
      end
    end
  end

  // ==========================================
  // pins and interrupts
  // idle level is the polarity bit itself
  assign next_pulse0 = level0 ^ ctrl0[`PLSGEN_POL_BIT];
  assign next_pulse1 = (mode16 ? level0 : level1) ^ ctrl1[`PLSGEN_POL_BIT];

  always @(posedge clock) begin
    if (rst) begin
      pulse_out0 <= 1'b0;
      pulse_out1 <= 1'b0;
      pulse_prev1 <= 1'b0;
      irq0 <= 1'b0;
      irq1 <= 1'b0;
    end else begin
      pulse_out0 <= next_pulse0;
      pulse_out1 <= next_pulse1;
      pulse_prev1 <= pulse_out1;
      irq0 <= ctrl0[`PLSGEN_UF_BIT] & ctrl0[`PLSGEN_IEN_BIT];
      irq1 <= ctrl1[`PLSGEN_UF_BIT] & ctrl1[`PLSGEN_IEN_BIT];
    end
  end
endmodule // plsgen_top

// *** test/plsgen_props.sv ***
`timescale 1ns/1ns
module plsgen_props (
  input wire clock,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire pulse_out0,
  input wire irq0,
  input wire irq1
);
  reg [7:0] c0;
  reg [7:0] c1;
  reg run0;
  wire wr = psel && penable && pready && pwrite;
  // ====
  // software view of control bits
  always @(posedge clock) begin
    if (rst) begin
      c0 <= 8'h00;
      c1 <= 8'h00;
      run0 <= 1'b0;
    end else if (wr) begin
      if (paddr == 8'h00) c0 <= pwdata[7:0];
      if (paddr == 8'h04) c1 <= pwdata[7:0];
      if (paddr == 8'h08) run0 <= pwdata[0];
    end
  end
  // ====
  // properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_apb_ready: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_apb_err: assert property (psel && !penable && paddr > 8'h24 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_idle_level: assert property (!run0 && !$past(run0) && !$past(run0, 2) && c0[7] == $past(c0[7])
    |-> pulse_out0 == c0[7])
    else $error("pin not idle while stopped");
  a_start_low: assert property ($rose(run0) |-> (pulse_out0 == c0[7]) [*2])
    else $error("start did not begin low");
  a_irq_gate: assert property (irq0 |-> $past(c0[6]))
    else $error("irq without enable");
  a_irq_off: assert property (wr && paddr == 8'h00 && !pwdata[6] |-> ##2 !irq0)
    else $error("irq after disable");
  a_gang_flags: assert property (c0[3:2] == 2'h2 && c1[6] && $past(c1[6]) && $rose(irq0) |-> irq1)
    else $error("joined flags apart");
endmodule // plsgen_props
bind plsgen_top plsgen_props i_props (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pulse_out0(pulse_out0), .irq0(irq0), .irq1(irq1));

// *** test/programmable_pulse_generator_test.sv ***
`timescale 1ns/1ns
module programmable_pulse_generator_test;
  reg clock = 1'b0;
  reg rst = 1'b1;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready, pslverr, pulse_out0, pulse_out1, irq0, irq1;
  reg [31:0] rd;
  reg err;
  reg [15:0] r = 16'hc70b;
  integer fail_count = 0, checked = 0, cyc = 0, k, n, h, l, m, f;
  plsgen_top i_dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pulse_out0(pulse_out0),
    .pulse_out1(pulse_out1), .irq0(irq0), .irq1(irq1));
  always #4 clock = ~clock;
  // ====
  // hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      stop_test;
    end
  end
  // ====
  // helpers
  function [15:0] lf(input [15:0] s);
    lf = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // clocks spent at level lv, waiting for it first
  task phase(input lv, output integer c);
    c = 0;
    while (pulse_out0 !== lv) @(posedge clock);
    while (pulse_out0 === lv) begin
      @(posedge clock);
      c = c + 1;
    end
  endtask
  task stop_test;
    if (fail_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ====
  // sequence
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    apb(0, 8'h00, 0);
    chk(rd, 0);
    apb(0, 8'h30, 0);
    chk(err, 1);
    for (k = 0; k < 8; k = k + 1) begin
      r = lf(r);
      h = r[1:0];
      l = r[3:2];
      m = 1 << (2 * k[1:0]);
      apb(1, 8'h0c, h);
      apb(1, 8'h10, l);
      apb(1, 8'h00, {24'h0, k[2], 5'h0, k[1:0]});
      apb(1, 8'h08, 1);
      phase(!k[2], n);
      chk(n, m * (h + 1));
      phase(k[2], n);
      chk(n, m * (l + 1));
      apb(1, 8'h08, 0);
      repeat (3) @(posedge clock);
      chk(pulse_out0, k[2]);
    end
    for (f = 0; f < 2; f = f + 1) begin
      apb(1, 8'h0c, 20);
      apb(1, 8'h10, 1);
      apb(1, 8'h00, f ? 32'hd0 : 32'h40);
      apb(1, 8'h08, 1);
      while (pulse_out0 !== !f[0]) @(posedge clock);
      repeat (2) @(posedge clock);
      apb(0, 8'h00, 0);
      chk(rd[5], !f[0]);
      while (pulse_out0 !== f[0]) @(posedge clock);
      repeat (3) @(posedge clock);
      apb(0, 8'h00, 0);
      chk(rd[5], 1);
      chk(irq0, 1);
      apb(1, 8'h08, 0);
      apb(1, 8'h00, 0);
      apb(0, 8'h00, 0);
      chk(rd[5], 0);
      chk(irq0, 0);
    end
    apb(1, 8'h0c, 2);
    apb(1, 8'h10, 12);
    apb(1, 8'h08, 1);
    phase(1, n);
    apb(1, 8'h0c, 5);
    apb(1, 8'h10, 6);
    phase(1, n);
    chk(n, 3);
    phase(0, n);
    chk(n, 7);
    phase(1, n);
    chk(n, 6);
    apb(1, 8'h08, 0);
    apb(1, 8'h0c, 0);
    apb(1, 8'h14, 1);
    apb(1, 8'h10, 1);
    apb(1, 8'h18, 0);
    apb(1, 8'h04, 32'h40);
    apb(1, 8'h00, 32'h48);
    apb(1, 8'h08, 3);
    phase(1, n);
    chk(n, 257);
    chk(pulse_out1, 0);
    phase(0, n);
    chk(n, 2);
    repeat (4) @(posedge clock);
    chk(irq1, 1);
    apb(1, 8'h08, 0);
    for (f = 0; f < 2; f = f + 1) begin
      apb(1, 8'h0c, 2);
      apb(1, 8'h10, 4);
      apb(1, 8'h14, 1);
      apb(1, 8'h18, 1);
      apb(1, 8'h04, f ? 32'h80 : 32'h00);
      apb(1, 8'h00, 32'h07);
      apb(1, 8'h08, 3);
      phase(1, n);
      chk(n, 6);
      phase(0, n);
      chk(n, 10);
      apb(1, 8'h08, 0);
      repeat (3) @(posedge clock);
      chk(pulse_out1, f[0]);
    end
    stop_test;
  end
endmodule // programmable_pulse_generator_test
